// ==== logic/rtcx_top.sv ====
// RTC register access: indexed standard and extended banks behind
// four host I/O ports, control register A and the divider chain.
// Assumes one-cycle request strobes in the core clock domain and a
// free running oscillator pin that is synchronised here.
//
// Summary of operation
// - Two indexed banks, standard and extended, 128 bytes each.
// - First 14 standard bytes: time and alarms, date, then A to D.
// - Extended RAM stays usable while the clock is disabled.
// - Host reaches everything through I/O ports 70h to 73h.
// - Ports 72h and 73h can be disabled and then ignore the host.
// - 72h write loads extended pointer; 73h moves data there.
// - Alarm byte C0h to FFh matches any time value.
// - Only PCI master cycles are served, ISA masters ignored.
// - Index map: time, alarms, date, A to D, user RAM 0Eh-7Fh.
// - Register A is never changed by any reset.
// - Update pending reads 1 when an update is near or running.
// - Pending clear guarantees no update for the lead interval.
// - Divider field 010 runs, 11x holds divider in reset.
// - Patterns 101, 100, 011 bypass 15, 10, 5 stages.
// - Rate field picks a tap; sets flag, interrupt if enabled.
// - 32.768 kHz oscillator divided down to one hertz.
`timescale 1ns/1ps
`default_nettype none
module rtcx_top (
    // Clock, reset and enable
    input  wire logic                   i_mclk,
    input  wire logic                   i_reset_n,
    input  wire logic                   i_ce,
    // Oscillator pin
    input  wire logic                   i_osc_32k,
    // Host I/O cycles
    input  wire rtcx_pkg::rtcx_io_req_s i_io_req,
    output var  rtcx_pkg::rtcx_io_rsp_s o_io_rsp,
    // Configuration
    input  wire logic                   i_rtc_enable,
    input  wire logic                   i_ext_enable,
    // Status and events
    output var  logic                   o_uip,
    output var  logic                   o_sec_tick,
    output var  logic                   o_periodic_irq,
    output var  logic                   o_alarm_match
);

    ////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] std_ram [rtcx_pkg::BANK_DEPTH];
    logic [7:0] ext_ram [rtcx_pkg::BANK_DEPTH];
    logic [6:0] std_ptr_q;
    logic [6:0] ext_ptr_q;
    logic [6:0] rega_q;
    logic       osc_s1_q;
    logic       osc_s2_q;
    logic       osc_s3_q;
    logic       osc_tick;
    logic       pf_q;
    logic       per_tick;
    logic       periodic_irq_enable;
    logic       acc;
    logic       wr_go;
    logic       rd_go;
    logic [7:0] rd_data;
    logic [7:0] std_peek;
    logic [7:0] ext_peek;
    logic [7:0] regc_val;
    logic [6:0] req_idx;
    rtcx_pkg::rtcx_sel_e sel;

    ////////////////////////////////////////////////////////////////
    // Helpers

    // Alarm byte compare with wildcard
    function automatic logic alarm_hit(input logic [7:0] alm,
                                       input logic [7:0] tim);
        alarm_hit = (alm[7:rtcx_pkg::ANY_LSB] == rtcx_pkg::ALARM_ANY)
                    || (alm == tim);
    endfunction

    // Port address compare
    function automatic logic port_is(input logic [15:0] addr,
                                     input logic [15:0] port);
        port_is = (addr == port);
    endfunction

    ////////////////////////////////////////////////////////////////
    // Oscillator pin synchroniser and edge detect
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            osc_s1_q <= 1'h0;
            osc_s2_q <= 1'h0;
            osc_s3_q <= 1'h0;
        end else if (i_ce) begin
            osc_s1_q <= i_osc_32k;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    assign osc_tick = osc_s2_q && !osc_s3_q;

    ////////////////////////////////////////////////////////////////
    // Port decode
    always_comb begin
        acc = i_io_req.wr || i_io_req.rd;
        sel = rtcx_pkg::SEL_NONE;
        if (!acc || !i_io_req.pci) begin
            sel = rtcx_pkg::SEL_NONE;
        end else if (i_rtc_enable &&
                port_is(i_io_req.addr, rtcx_pkg::PORT_STD_IDX)) begin
            sel = rtcx_pkg::SEL_STD_IDX;
        end else if (i_rtc_enable &&
                port_is(i_io_req.addr, rtcx_pkg::PORT_STD_DATA)) begin
            sel = rtcx_pkg::SEL_STD_DATA;
        end else if (i_ext_enable &&
                port_is(i_io_req.addr, rtcx_pkg::PORT_EXT_IDX)) begin
            sel = rtcx_pkg::SEL_EXT_IDX;
        end else if (i_ext_enable &&
                port_is(i_io_req.addr, rtcx_pkg::PORT_EXT_DATA)) begin
            sel = rtcx_pkg::SEL_EXT_DATA;
        end
        wr_go = i_ce && i_reset_n && i_io_req.wr;
        rd_go = i_ce && i_reset_n && i_io_req.rd;
    end

    assign req_idx  = i_io_req.wdata[6:0];
    assign std_peek = std_ram[std_ptr_q];
    assign ext_peek = ext_ram[ext_ptr_q];
    assign periodic_irq_enable      = std_ram[rtcx_pkg::IDX_REG_B][rtcx_pkg::PIE_BIT];

    ////////////////////////////////////////////////////////////////
    // standard pointer at 70h
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            std_ptr_q <= '0;
        end else if (wr_go && sel == rtcx_pkg::SEL_STD_IDX) begin
            std_ptr_q <= req_idx;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ext_ptr_q <= '0;
        end else if (wr_go && sel == rtcx_pkg::SEL_EXT_IDX) begin
            ext_ptr_q <= req_idx;
        end
    end

    ////////////////////////////////////////////////////////////////
    // standard bank storage, battery backed
    // registers A and C held apart
    always_ff @(posedge i_mclk) begin
        if (wr_go && sel == rtcx_pkg::SEL_STD_DATA &&
                std_ptr_q != rtcx_pkg::IDX_REG_A &&
                std_ptr_q != rtcx_pkg::IDX_REG_C) begin
            std_ram[std_ptr_q] <= i_io_req.wdata;
        end
    end

    // extended bank, independent of RTC enable
    always_ff @(posedge i_mclk) begin
        if (wr_go && sel == rtcx_pkg::SEL_EXT_DATA) begin
            ext_ram[ext_ptr_q] <= i_io_req.wdata;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (wr_go && sel == rtcx_pkg::SEL_STD_DATA &&
                std_ptr_q == rtcx_pkg::IDX_REG_A) begin
            rega_q <= i_io_req.wdata[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read data mux
    always_comb begin
        regc_val = '0;
        regc_val[rtcx_pkg::IRQF_BIT] = pf_q && periodic_irq_enable;
        regc_val[rtcx_pkg::PF_BIT]   = pf_q;
        rd_data = '0;
        case (sel)
            rtcx_pkg::SEL_STD_IDX: rd_data = {1'h0, std_ptr_q};
            rtcx_pkg::SEL_EXT_IDX: rd_data = {1'h0, ext_ptr_q};
            rtcx_pkg::SEL_EXT_DATA: rd_data = ext_peek;
            rtcx_pkg::SEL_STD_DATA: begin
                if (std_ptr_q == rtcx_pkg::IDX_REG_A) begin
                    rd_data = {o_uip, rega_q};
                end else if (std_ptr_q == rtcx_pkg::IDX_REG_C) begin
                    rd_data = regc_val;
                end else begin
                    rd_data = std_peek;
                end
            end
            default: rd_data = '0;
        endcase
    end

    // Answer one cycle after a claimed request
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_io_rsp <= '0;
        end else if (i_ce) begin
            o_io_rsp.ack   <= sel != rtcx_pkg::SEL_NONE;
            o_io_rsp.rdata <= i_io_req.rd ? rd_data : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // divider under register A control
    rtcx_divider u_divider (
        .i_mclk     (i_mclk),
        .i_reset_n  (i_reset_n),
        .i_ce       (i_ce),
        .i_run      (i_rtc_enable),
        .i_osc_tick (osc_tick),
        .i_dv       (rega_q[rtcx_pkg::DV_LSB +: rtcx_pkg::DV_W]),
        .i_rs       (rega_q[rtcx_pkg::RS_LSB +: rtcx_pkg::RS_W]),
        .o_sec_tick (o_sec_tick),
        .o_per_tick (per_tick),
        .o_uip      (o_uip)
    );

    ////////////////////////////////////////////////////////////////
    // periodic flag, set wins over read clear
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            pf_q <= 1'h0;
        end else if (i_ce) begin
            if (per_tick) begin
                pf_q <= 1'h1;
            end else if (rd_go && sel == rtcx_pkg::SEL_STD_DATA &&
                    std_ptr_q == rtcx_pkg::IDX_REG_C) begin
                pf_q <= 1'h0;
            end
        end
    end

    // Periodic interrupt when enabled
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_periodic_irq <= 1'h0;
        end else if (i_ce) begin
            o_periodic_irq <= pf_q && periodic_irq_enable;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_alarm_match <= 1'h0;
        end else if (i_ce) begin
            o_alarm_match <=
                alarm_hit(std_ram[rtcx_pkg::IDX_ALM_SEC],
                          std_ram[rtcx_pkg::IDX_SEC]) &&
                alarm_hit(std_ram[rtcx_pkg::IDX_ALM_MIN],
                          std_ram[rtcx_pkg::IDX_MIN]) &&
                alarm_hit(std_ram[rtcx_pkg::IDX_ALM_HOUR],
                          std_ram[rtcx_pkg::IDX_HOUR]);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    logic [7:0] alm_s;
    logic [7:0] alm_m;
    logic [7:0] alm_h;
    assign alm_s = std_ram[rtcx_pkg::IDX_ALM_SEC];
    assign alm_m = std_ram[rtcx_pkg::IDX_ALM_MIN];
    assign alm_h = std_ram[rtcx_pkg::IDX_ALM_HOUR];

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    // Accepted request steps
    sequence s_pci_req;
        i_ce && i_io_req.pci && (i_io_req.wr || i_io_req.rd);
    endsequence

    sequence s_std_data_req;
        s_pci_req ##0 i_rtc_enable &&
            i_io_req.addr == rtcx_pkg::PORT_STD_DATA;
    endsequence

    sequence s_ext_read;
        i_ce && i_io_req.pci && i_io_req.rd && i_ext_enable &&
            i_io_req.addr == rtcx_pkg::PORT_EXT_DATA;
    endsequence

    sequence s_ext_ptr_write;
        i_ce && i_io_req.pci && i_io_req.wr && i_ext_enable &&
            i_io_req.addr == rtcx_pkg::PORT_EXT_IDX;
    endsequence

    property p_std_ack;
        s_std_data_req |=> o_io_rsp.ack;
    endproperty
    a_std_ack: assert property (p_std_ack)
        else $error("standard data access not answered");

    property p_isa_ignored;
        i_ce && !i_io_req.pci && (i_io_req.wr || i_io_req.rd)
            |=> !o_io_rsp.ack;
    endproperty
    a_isa_ignored: assert property (p_isa_ignored)
        else $error("non PCI cycle was answered");

    property p_ext_off;
        i_ce && !i_ext_enable && (i_io_req.wr || i_io_req.rd) &&
            (i_io_req.addr == rtcx_pkg::PORT_EXT_IDX ||
             i_io_req.addr == rtcx_pkg::PORT_EXT_DATA)
            |=> !o_io_rsp.ack;
    endproperty
    a_ext_off: assert property (p_ext_off)
        else $error("disabled upper port answered");

    property p_ext_read;
        s_ext_read |=> o_io_rsp.ack && o_io_rsp.rdata == $past(ext_peek);
    endproperty
    a_ext_read: assert property (p_ext_read)
        else $error("extended read data wrong");

    property p_ext_ptr;
        s_ext_ptr_write |=> ext_ptr_q == $past(req_idx);
    endproperty
    a_ext_ptr: assert property (p_ext_ptr)
        else $error("extended pointer not loaded");

    property p_ext_clock_off;
        s_ext_read ##0 !i_rtc_enable |=> o_io_rsp.ack;
    endproperty
    a_ext_clock_off: assert property (p_ext_clock_off)
        else $error("extended bank lost with clock off");

    property p_rega_keep;
        $rose(i_reset_n) && $past(i_reset_n, 3) |-> rega_q == $past(rega_q, 2);
    endproperty
    a_rega_keep: assert property (p_rega_keep)
        else $error("register A changed across reset");

    property p_alarm_any;
        i_ce && alm_s[7:6] == rtcx_pkg::ALARM_ANY &&
            alm_m[7:6] == rtcx_pkg::ALARM_ANY &&
            alm_h[7:6] == rtcx_pkg::ALARM_ANY |=> o_alarm_match;
    endproperty
    a_alarm_any: assert property (p_alarm_any)
        else $error("wildcard alarm did not match");

    property p_pf_set;
        i_ce && per_tick |=> pf_q ##1 (pf_q || !i_ce || $past(rd_go));
    endproperty
    a_pf_set: assert property (p_pf_set)
        else $error("periodic flag not set by tap");

endmodule
`default_nettype wire

// ==== logic/rtcx_pkg.sv ====
// Constants and carriers for the RTC register access block.
// Assumes a 25 MHz core clock and a 32.768 kHz oscillator pin.
package rtcx_pkg;

    // Host I/O ports
    localparam logic [15:0] PORT_STD_IDX  = 16'h0070;
    localparam logic [15:0] PORT_STD_DATA = 16'h0071;
    localparam logic [15:0] PORT_EXT_IDX  = 16'h0072;
    localparam logic [15:0] PORT_EXT_DATA = 16'h0073;

    // Bank geometry and standard bank index map
    localparam int IDX_W      = 7;
    localparam int BANK_DEPTH = 128;
    localparam logic [6:0] IDX_SEC       = 7'h00;
    localparam logic [6:0] IDX_ALM_SEC   = 7'h01;
    localparam logic [6:0] IDX_MIN       = 7'h02;
    localparam logic [6:0] IDX_ALM_MIN   = 7'h03;
    localparam logic [6:0] IDX_HOUR      = 7'h04;
    localparam logic [6:0] IDX_ALM_HOUR  = 7'h05;
    localparam logic [6:0] IDX_WEEKDAY   = 7'h06;
    localparam logic [6:0] IDX_DAY       = 7'h07;
    localparam logic [6:0] IDX_MONTH     = 7'h08;
    localparam logic [6:0] IDX_YEAR      = 7'h09;
    localparam logic [6:0] IDX_REG_A     = 7'h0a;
    localparam logic [6:0] IDX_REG_B     = 7'h0b;
    localparam logic [6:0] IDX_REG_C     = 7'h0c;
    localparam logic [6:0] IDX_REG_D     = 7'h0d;
    localparam logic [6:0] IDX_USER_BASE = 7'h0e;

    // Control register fields
    localparam int UIP_BIT  = 7;
    localparam int DV_LSB   = 4;
    localparam int DV_W     = 3;
    localparam int RS_LSB   = 0;
    localparam int RS_W     = 4;
    localparam int PIE_BIT  = 6;
    localparam int IRQF_BIT = 7;
    localparam int PF_BIT   = 6;
    localparam int ANY_LSB  = 6;
    localparam logic [1:0] ALARM_ANY = 2'h3;

    // Divider select patterns
    localparam logic [2:0] DV_NORMAL  = 3'h2;
    localparam logic [2:0] DV_BYP15   = 3'h5;
    localparam logic [2:0] DV_BYP10   = 3'h4;
    localparam logic [2:0] DV_BYP5    = 3'h3;
    localparam logic [1:0] DV_RST_MSB = 2'h3;
    localparam int DIV_W    = 15;
    localparam int SH_BYP5  = 5;
    localparam int SH_BYP10 = 10;
    localparam int SH_BYP15 = 15;

    // Periodic rate taps
    localparam logic [3:0] RS_NONE   = 4'h0;
    localparam logic [3:0] RS_SLOW1  = 4'h1;
    localparam logic [3:0] RS_SLOW2  = 4'h2;
    localparam logic [3:0] TAP_SLOW1 = 4'h6;
    localparam logic [3:0] TAP_SLOW2 = 4'h7;
    localparam logic [3:0] TAP_OFS   = 4'h2;

    // Update pending lead time, in oscillator ticks (rounded up)
    localparam longint OSC_HZ      = 64'h0000_0000_0000_8000;
    localparam longint UIP_LEAD_NS = 64'h0000_0000_0003_B920;
    localparam longint NS_PER_S    = 64'h0000_0000_3B9A_CA00;
    localparam longint LEAD_L =
        (UIP_LEAD_NS * OSC_HZ + NS_PER_S - 1) / NS_PER_S;
    localparam logic [3:0] UIP_LEAD_OSC = 4'(LEAD_L);
    localparam logic [DIV_W-1:0] PEND_START =
        DIV_W'((longint'(1) << DIV_W) - LEAD_L);
    localparam logic [3:0] UPD_HOLD_OSC = 4'h8;

    // Port selection and bus carriers
    typedef enum logic [2:0] {
        SEL_NONE, SEL_STD_IDX, SEL_STD_DATA, SEL_EXT_IDX, SEL_EXT_DATA
    } rtcx_sel_e;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
        logic        pci;
    } rtcx_io_req_s;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
    } rtcx_io_rsp_s;

endpackage

// ==== logic/rtcx_divider.sv ====
// Oscillator divider chain, update pending window and periodic tap.
// Assumes i_osc_tick is a one-cycle pulse already in the core domain.
`timescale 1ns/1ps
`default_nettype none
module rtcx_divider (
    // Clock and control
    input  wire logic       i_mclk,
    input  wire logic       i_reset_n,
    input  wire logic       i_ce,
    input  wire logic       i_run,
    // Time base and selects
    input  wire logic       i_osc_tick,
    input  wire logic [2:0] i_dv,
    input  wire logic [3:0] i_rs,
    // Events
    output var  logic       o_sec_tick,
    output var  logic       o_per_tick,
    output var  logic       o_uip
);
    logic [rtcx_pkg::DIV_W-1:0] cnt_q;
    logic [rtcx_pkg::DIV_W:0]   step;
    logic [rtcx_pkg::DIV_W:0]   sum;
    logic [3:0]                 hold_q;
    logic [3:0]                 tap;
    logic                       held;
    logic                       bypass;
    logic                       uip_d;
    logic                       per_d;

    ////////////////////////////////////////////////////////////////
    // Step size, hold state and tap selection
    always_comb begin
        step   = '0;
        bypass = 1'h0;
        case (i_dv)
            rtcx_pkg::DV_NORMAL: step = 16'h0001;
            rtcx_pkg::DV_BYP5: begin
                step   = 16'h0001 << rtcx_pkg::SH_BYP5;
                bypass = 1'h1;
            end
            rtcx_pkg::DV_BYP10: begin
                step   = 16'h0001 << rtcx_pkg::SH_BYP10;
                bypass = 1'h1;
            end
            rtcx_pkg::DV_BYP15: begin
                step   = 16'h0001 << rtcx_pkg::SH_BYP15;
                bypass = 1'h1;
            end
            default: step = '0;
        endcase
        sum = {1'h0, cnt_q} + step;
        held = (i_dv[2:1] == rtcx_pkg::DV_RST_MSB) || !i_run;
        if (i_rs == rtcx_pkg::RS_SLOW1) begin
            tap = rtcx_pkg::TAP_SLOW1;
        end else if (i_rs == rtcx_pkg::RS_SLOW2) begin
            tap = rtcx_pkg::TAP_SLOW2;
        end else begin
            tap = i_rs - rtcx_pkg::TAP_OFS;
        end
        per_d = i_osc_tick && !held && (i_rs != rtcx_pkg::RS_NONE)
                && sum[tap] && !cnt_q[tap];
        uip_d = !held && ((step == 16'h0001 &&
                cnt_q >= rtcx_pkg::PEND_START) ||
                hold_q != 4'h0 || bypass);
    end

    ////////////////////////////////////////////////////////////////
    // divide oscillator to seconds
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cnt_q <= '0;
        end else if (i_ce) begin
            if (held) begin
                cnt_q <= '0;
            end else if (i_osc_tick) begin
                cnt_q <= sum[rtcx_pkg::DIV_W-1:0];
            end
        end
    end

    // Second and periodic pulses
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_sec_tick <= 1'h0;
            o_per_tick <= 1'h0;
        end else if (i_ce) begin
            o_sec_tick <= i_osc_tick && !held
                          && sum[rtcx_pkg::DIV_W];
            o_per_tick <= per_d;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            hold_q <= 4'h0;
            o_uip  <= 1'h0;
        end else if (i_ce) begin
            o_uip <= uip_d;
            if (held) begin
                hold_q <= 4'h0;
            end else if (i_osc_tick && sum[rtcx_pkg::DIV_W]) begin
                hold_q <= rtcx_pkg::UPD_HOLD_OSC;
            end else if (i_osc_tick && hold_q != 4'h0) begin
                hold_q <= hold_q - 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    logic [3:0] uip_osc_q;
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n || !o_uip) begin
            uip_osc_q <= 4'h0;
        end else if (i_ce && i_osc_tick && uip_osc_q != 4'hf) begin
            uip_osc_q <= uip_osc_q + 4'h1;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    property p_tick_in_uip;
        o_sec_tick |-> o_uip;
    endproperty
    a_tick_in_uip: assert property (p_tick_in_uip)
        else $error("second tick without update pending");

    property p_uip_lead;
        o_sec_tick && !bypass |-> uip_osc_q >= rtcx_pkg::UIP_LEAD_OSC;
    endproperty
    a_uip_lead: assert property (p_uip_lead)
        else $error("update pending window too short");

    property p_div_reset;
        i_ce && i_dv[2:1] == rtcx_pkg::DV_RST_MSB |=> cnt_q == '0;
    endproperty
    a_div_reset: assert property (p_div_reset)
        else $error("divider not held in reset");

    property p_byp15;
        i_ce && i_run && i_osc_tick && i_dv == rtcx_pkg::DV_BYP15
            |=> o_sec_tick;
    endproperty
    a_byp15: assert property (p_byp15)
        else $error("full bypass did not tick");

    property p_rate_none;
        i_ce && i_rs == rtcx_pkg::RS_NONE |=> !o_per_tick;
    endproperty
    a_rate_none: assert property (p_rate_none)
        else $error("periodic tick with rate none");

endmodule
`default_nettype wire

// ==== bench/rtcx_host.sv ====
// Host model: issues one-cycle I/O cycles on the register ports.
// Assumes the caller runs in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module rtcx_host (
    // Clock
    input  wire logic                   i_mclk,
    // I/O cycle
    output var  rtcx_pkg::rtcx_io_req_s o_req,
    input  wire rtcx_pkg::rtcx_io_rsp_s i_rsp
);
    initial o_req = '0;
    task automatic xfer(input logic [15:0] a, input logic w,
                        input logic [7:0] d, input logic p,
                        output logic [7:0] q, output logic k);
        @(posedge i_mclk) #1;
        o_req = '{addr: a, wr: w, rd: !w, wdata: d, pci: p};
        @(posedge i_mclk) #1;
        k = i_rsp.ack;
        q = i_rsp.rdata;
        // Idle bus shows the inverse of the last value
        o_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d, pci: !p};
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_rtcx_top.sv ====
// Bench for the register access block: port accesses and divider.
// Assumes the host model in rtcx_host and a fast oscillator.
`timescale 1ns/1ps
`default_nettype none
module tb_rtcx_top;
    localparam logic [15:0] SI = rtcx_pkg::PORT_STD_IDX;
    localparam logic [15:0] SD = rtcx_pkg::PORT_STD_DATA;
    localparam logic [15:0] EI = rtcx_pkg::PORT_EXT_IDX;
    localparam logic [15:0] ED = rtcx_pkg::PORT_EXT_DATA;
    logic mclk = 0, reset_n = 0, osc = 0, rtc_en = 1, ext_en = 1, ce = 1;
    logic update_pending_flag, sec_tick, alarm, irq, k;
    logic [7:0]  q;
    logic [7:0]  mode [4] = '{8'h50, 8'h40, 8'h30, 8'h60};
    int          span [4] = '{64, 1024, 16384, 64};
    int          want [4] = '{8, 4, 2, 0};
    int          bad_count = 0, tests_run = 0, cycles = 0, ticks;
    rtcx_pkg::rtcx_io_req_s req;
    rtcx_pkg::rtcx_io_rsp_s rsp;
    ////////////////////////////////////////////////////////////////////
    // Clocks: core 40 ns, oscillator 8 core cycles
    always #20 mclk = ~mclk;
    always #160 osc = ~osc;
    rtcx_host u_rtcx_host (.i_mclk(mclk), .o_req(req), .i_rsp(rsp));
    rtcx_top u_rtcx_top (
        .i_mclk(mclk), .i_reset_n(reset_n), .i_ce(ce),
        .i_osc_32k(osc), .i_io_req(req), .o_io_rsp(rsp),
        .i_rtc_enable(rtc_en), .i_ext_enable(ext_en), .o_uip(update_pending_flag),
        .o_sec_tick(sec_tick), .o_periodic_irq(irq), .o_alarm_match(alarm)
    );
    ////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string n, input logic [8:0] s, e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    // One access, ack and data compared as {ack, rdata}
    task automatic acc(input logic [15:0] a, input logic w,
                       input logic [7:0] d, input logic [8:0] e);
        u_rtcx_host.xfer(a, w, d, 1'b1, q, k);
        check("access", {k, q}, e);
    endtask
    task automatic test_done;
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk);
        #1 reset_n = 1;
        acc(SI, 1, 8'h0a, 9'h100);
        acc(SD, 1, 8'h20, 9'h100);
        acc(SI, 1, 8'h7f, 9'h100);
        acc(SD, 1, 8'ha5, 9'h100);
        acc(SI, 0, 8'h00, 9'h17f);
        acc(SD, 0, 8'h00, 9'h1a5);
        // Update inhibit set, pending flag clear before time writes
        acc(SI, 1, 8'h0b, 9'h100);
        acc(SD, 1, 8'h80, 9'h100);
        acc(SI, 1, 8'h0a, 9'h100);
        acc(SD, 0, 8'h00, 9'h120);
        // Alarm bytes C0h match any time
        for (int i = 0; i < 6; i++) begin
            acc(SI, 1, 8'(i), 9'h100);
            acc(SD, 1, (i % 2) ? 8'hc0 : 8'h12, 9'h100);
        end
        repeat (2) @(posedge mclk);
        #1 check("alarm any", {8'h00, alarm}, 9'h001);
        acc(SI, 1, 8'h01, 9'h100);
        acc(SD, 1, 8'h11, 9'h100);
        repeat (2) @(posedge mclk);
        #1 check("alarm miss", {8'h00, alarm}, 9'h000);
        // Register A survives reset
        reset_n = 0;
        repeat (2) @(posedge mclk);
        #1 reset_n = 1;
        acc(SI, 1, 8'h0a, 9'h100);
        acc(SD, 0, 8'h00, 9'h120);
        // Divider modes: bypass 15, 10 and 5, held in reset
        for (int m = 0; m < 4; m++) begin
            acc(SD, 1, mode[m], 9'h100);
            ticks = 0;
            repeat (span[m]) begin
                @(posedge mclk) #1;
                ticks += int'(sec_tick);
            end
            check("ticks", 9'(ticks + 1 >= want[m] && ticks <= want[m] + 1),
                  9'h001);
            check("pend", {8'h00, update_pending_flag}, 9'(m < 3));
        end
        // Periodic rate 0011 with the enable bit set
        acc(SD, 1, 8'h23, 9'h100);
        acc(SI, 1, 8'h0b, 9'h100);
        acc(SD, 1, 8'h40, 9'h100);
        repeat (40) @(posedge mclk);
        #1 check("periodic irq", {8'h00, irq}, 9'h001);
        acc(SI, 1, 8'h0c, 9'h100);
        acc(SD, 0, 8'h00, 9'h1c0);
        // Extended bank with the clock disabled
        rtc_en = 0;
        acc(SI, 1, 8'h0e, 9'h000);
        acc(EI, 1, 8'h05, 9'h100);
        acc(ED, 1, 8'h3c, 9'h100);
        acc(ED, 0, 8'h00, 9'h13c);
        // Frozen write with the clock enable low must not land
        @(posedge mclk) #1 ce = 0;
        acc(ED, 1, 8'h77, 9'h000);
        ce = 1;
        acc(ED, 0, 8'h00, 9'h13c);
        u_rtcx_host.xfer(ED, 0, 8'h00, 1'b0, q, k);
        check("isa master", {k, q}, 9'h000);
        ext_en = 0;
        acc(ED, 0, 8'h00, 9'h000);
        test_done();
    end
endmodule
`default_nettype wire
